// ### hdl/dmra_regs.vh
// address map, field positions, reset values and codes of the memory access unit
`ifndef DMRA_REGS_VH
`define DMRA_REGS_VH

// peripheral addresses for buffer transfers
`define DMRA_PA_CARRIER_LOW   8'h03
`define DMRA_PA_CARRIER_HIGH  8'h04
`define DMRA_PA_TIMER_COUNT   8'h05
`define DMRA_PA_TIMER_MODULO  8'h06
`define DMRA_PA_ADDR_POINTER  8'h40

// data memory locations
`define DMRA_DBF_ROW          3'h0
`define DMRA_DBF_COL_HI       2'h3
`define DMRA_PORT_A_ADDR      7'h70
`define DMRA_SYS_ROW          3'h7
`define DMRA_SYS_FIRST_COL    4'h4

// system register slots, indexed by the low address nibble
`define DMRA_SYS_AR3          4'h4
`define DMRA_SYS_AR2          4'h5
`define DMRA_SYS_AR1          4'h6
`define DMRA_SYS_AR0          4'h7
`define DMRA_SYS_WR           4'h8
`define DMRA_SYS_RPH          4'hD
`define DMRA_SYS_RPL          4'hE

// field positions
`define DMRA_RPL_ROW_MSB      3
`define DMRA_RPL_ROW_LSB      1
`define DMRA_RPH_BANK_MSB     1
`define DMRA_RPH_BANK_LSB     0
`define DMRA_AR3_KEEP         4'h3
`define DMRA_RF_CTRL_BIT      6

// reset values
`define DMRA_DBF_RESET        16'h0320
`define DMRA_NIB_ZERO         4'h0
`define DMRA_BYTE_ZERO        8'h00
`define DMRA_CTRL_IMPL        64'h008700E0_80FF00FF
`define DMRA_CTRL_RDONLY      64'h00000000_00000000

// operation codes on the general register path
`define DMRA_OP_LOAD          2'h0
`define DMRA_OP_STORE         2'h1
`define DMRA_OP_ADD           2'h2
`define DMRA_OP_AND           2'h3

`endif

// ### hdl/dmra_access.v
// data memory, buffer, register file and key port access unit of the 4-bit cpu
`timescale 1ns/1ps
`include "dmra_regs.vh"
// What this block does
// RL1 - window is one 16-nibble row of memory
// RL2 - row from pointer low bits 1-3, bank high 0-1
// RL3 - window rows limited to 0H through 7H
// RL4 - one-step operation between memory and window row
// RL5 - buffer sits at nibbles 0CH to 0FH
// RL6 - timer count read-only, timer modulo write-only
// RL7 - carrier low modulo readable and writable
// RL8 - carrier high modulo readable and writable
// RL9 - top pointer nibble bits 2,3 ignored on write
// RL10 - top pointer nibble bits 2,3 read zero
// RL11 - table read loads program word into buffer
// RL12 - bad peripheral writes ignored, reads undefined
// RL13 - control registers hide memory 00H-3FH
// RL14 - file addresses 40H-7FH reach data memory
// RL15 - only 24 of 64 control nibbles exist
// RL16 - file read copies nibble into window register
// RL17 - file write copies window register into nibble
// RL18 - bad control writes ignored, reads undefined
// RL19 - key port read at bank 0 70H
// RL20 - low key pin ends standby
// RL21 - transfers copy between buffer and peripheral
module dmra_access #(
  parameter [63:0] CTRL_IMPL   = `DMRA_CTRL_IMPL,
  parameter [63:0] CTRL_RDONLY = `DMRA_CTRL_RDONLY,
  parameter        ROM_AW      = 14
) (
  input  wire              i_clk,
  input  wire              i_nrst,
  input  wire              i_mem_we,
  input  wire              i_mem_re,
  input  wire [1:0]        i_mem_bank,
  input  wire [6:0]        i_mem_addr,
  input  wire [3:0]        i_mem_wdata,
  input  wire              i_op_valid,
  input  wire [1:0]        i_op_code,
  input  wire [3:0]        i_op_col,
  input  wire              i_file_read_instruction,
  input  wire              i_file_write_instruction,
  input  wire [6:0]        i_rf_addr,
  input  wire              i_xfer_put,
  input  wire              i_xfer_get,
  input  wire [7:0]        i_xfer_addr,
  input  wire [7:0]        i_timer_count,
  input  wire              i_table_read,
  input  wire              i_rom_valid,
  input  wire [15:0]       i_rom_data,
  input  wire [3:0]        i_key_a,
  input  wire              i_standby,
  output reg  [3:0]        o_rdata,
  output reg               o_rvalid,
  output reg  [7:0]        o_carrier_low_mod,
  output reg  [7:0]        o_carrier_high_mod,
  output reg  [7:0]        o_timer_mod,
  output reg               o_timer_mod_load,
  output reg  [ROM_AW-1:0] o_rom_addr,
  output reg               o_rom_req,
  output reg               o_wake
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [3:0]  mem [0:511];
  reg  [3:0]  sys [0:15];
  reg  [3:0]  dbf [0:3];
  reg  [3:0]  ctrl [0:63];
  reg  [3:0]  key_s1;
  reg  [3:0]  key_s2;
  reg  [3:0]  key_s3;
  reg  [3:0]  key_stable;

  integer     k;

  // buffer reset word split into nibbles by part-select, never by shift
  localparam [15:0] DBF_INIT = `DMRA_DBF_RESET;

  // window location: bank from pointer high, row from pointer low
  wire [1:0]  gr_bank = sys[`DMRA_SYS_RPH][`DMRA_RPH_BANK_MSB:`DMRA_RPH_BANK_LSB]; // see RL2
  wire [2:0]  gr_row  = sys[`DMRA_SYS_RPL][`DMRA_RPL_ROW_MSB:`DMRA_RPL_ROW_LSB]; // see RL2 see RL3
  wire [6:0]  gr_addr = {gr_row, i_op_col}; // see RL1

  wire [15:0] dbf_word = {dbf[3], dbf[2], dbf[1], dbf[0]};
  wire [13:0] ar_word  = {sys[`DMRA_SYS_AR3][1:0], sys[`DMRA_SYS_AR2],
                          sys[`DMRA_SYS_AR1], sys[`DMRA_SYS_AR0]};

  // ----------------------------------------------------------------
  // nibble read through the data memory map
  // ----------------------------------------------------------------
  function [3:0] rd_nib;
    input [1:0] bank;
    input [6:0] addr;
    begin
      if (addr[6:4] == `DMRA_SYS_ROW && addr[3:0] >= `DMRA_SYS_FIRST_COL)
        rd_nib = sys[addr[3:0]];
      else if (bank == 2'h0 && addr[6:4] == `DMRA_DBF_ROW && addr[3:2] == `DMRA_DBF_COL_HI)
        rd_nib = dbf[~addr[1:0]]; // see RL5
      else if (bank == 2'h0 && addr == `DMRA_PORT_A_ADDR)
        rd_nib = key_stable; // see RL19
      else
        rd_nib = mem[{bank, addr}];
    end
  endfunction

  // ----------------------------------------------------------------
  // single nibble write path, one source per cycle
  // ----------------------------------------------------------------
  reg         nw_en;
  reg  [1:0]  nw_bank;
  reg  [6:0]  nw_addr;
  reg  [3:0]  nw_data;
  reg  [3:0]  op_mem;
  reg  [3:0]  op_gr;
  reg         ctrl_hit;

  always @* begin
    nw_en    = 1'b0;
    nw_bank  = i_mem_bank;
    nw_addr  = i_mem_addr;
    nw_data  = i_mem_wdata;
    op_mem   = rd_nib(i_mem_bank, i_mem_addr);
    op_gr    = rd_nib(gr_bank, gr_addr);
    ctrl_hit = ~i_rf_addr[`DMRA_RF_CTRL_BIT];
    if (i_op_valid) begin
      nw_en = 1'b1;
      case (i_op_code) // see RL4
        `DMRA_OP_LOAD: begin
          nw_bank = gr_bank;
          nw_addr = gr_addr;
          nw_data = op_mem;
        end
        `DMRA_OP_STORE: begin
          nw_data = op_gr;
        end
        `DMRA_OP_ADD: begin
          nw_bank = gr_bank;
          nw_addr = gr_addr;
          nw_data = op_gr + op_mem;
        end
        default: begin
          nw_bank = gr_bank;
          nw_addr = gr_addr;
          nw_data = op_gr & op_mem;
        end
      endcase
    end else if (i_mem_we) begin
      nw_en = 1'b1;
    end else if (i_file_read_instruction) begin
      // window register is a system slot, same in every bank
      nw_en   = 1'b1;
      nw_addr = {`DMRA_SYS_ROW, `DMRA_SYS_WR};
      if (ctrl_hit)
        nw_data = ctrl[i_rf_addr[5:0]]; // see RL13 see RL16
      else
        nw_data = rd_nib(i_mem_bank, i_rf_addr); // see RL14 see RL16
      if (ctrl_hit && !CTRL_IMPL[i_rf_addr[5:0]])
        nw_data = `DMRA_NIB_ZERO; // see RL18
    end else if (i_file_write_instruction && !ctrl_hit) begin
      nw_en   = 1'b1;
      nw_addr = i_rf_addr; // see RL14 see RL17
      nw_data = sys[`DMRA_SYS_WR];
    end
  end

  // ----------------------------------------------------------------
  // write path decode: each nibble lands in at most one store, a key port write in none
  // ----------------------------------------------------------------
  wire        nw_sys   = (nw_addr[6:4] == `DMRA_SYS_ROW)
                         && (nw_addr[3:0] >= `DMRA_SYS_FIRST_COL);
  wire        nw_dbf   = (nw_bank == 2'h0) && (nw_addr[6:4] == `DMRA_DBF_ROW)
                         && (nw_addr[3:2] == `DMRA_DBF_COL_HI);
  wire        nw_port  = (nw_bank == 2'h0) && (nw_addr == `DMRA_PORT_A_ADDR);
  wire        mem_wr   = nw_en && !nw_sys && !nw_dbf && !nw_port;
  wire        sys_wr   = nw_en && nw_sys;
  wire        dbf_wr   = nw_en && !nw_sys && nw_dbf;
  // file_write_instruction owns the cycle only when no higher source claims the write path
  wire        file_write_instruction_sel = !i_op_valid && !i_mem_we && !i_file_read_instruction && i_file_write_instruction;
  wire        ctrl_wr  = file_write_instruction_sel && ctrl_hit
                         && CTRL_IMPL[i_rf_addr[5:0]] && !CTRL_RDONLY[i_rf_addr[5:0]];

  // ----------------------------------------------------------------
  // key port synchroniser
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_s1     <= 4'hF;
      key_s2     <= 4'hF;
      key_s3     <= 4'hF;
      key_stable <= 4'hF;
    end else begin
      key_s1 <= i_key_a;
      key_s2 <= key_s1;
      key_s3 <= key_s2;
      if (key_s2 == key_s3)
        key_stable <= key_s3;
    end
  end

  // ----------------------------------------------------------------
  // standby release
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wake <= 1'b0;
    end else begin
      // pull-ups hold idle pins high, so any zero is a pressed key
      o_wake <= i_standby && (key_stable != 4'hF); // see RL20
    end
  end

  // ----------------------------------------------------------------
  // read port: data one cycle after the request
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata  <= `DMRA_NIB_ZERO;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_mem_re;
      // data stands until the next read so a late sampler still sees it
      if (i_mem_re)
        o_rdata <= op_mem;
    end
  end

  // ----------------------------------------------------------------
  // memory array, no reset: contents undefined after power-up
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (mem_wr)
      mem[{nw_bank, nw_addr}] <= nw_data; // see RL1
  end

  // ----------------------------------------------------------------
  // system registers, buffer, control file, peripherals
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (k = 0; k < 16; k = k + 1)
        sys[k] <= `DMRA_NIB_ZERO;
      for (k = 0; k < 64; k = k + 1)
        ctrl[k] <= `DMRA_NIB_ZERO;
      dbf[0]             <= DBF_INIT[3:0];
      dbf[1]             <= DBF_INIT[7:4];
      dbf[2]             <= DBF_INIT[11:8];
      dbf[3]             <= DBF_INIT[15:12];
      o_carrier_low_mod  <= `DMRA_BYTE_ZERO;
      o_carrier_high_mod <= `DMRA_BYTE_ZERO;
      o_timer_mod        <= `DMRA_BYTE_ZERO;
      o_timer_mod_load   <= 1'b0;
      o_rom_addr         <= {ROM_AW{1'b0}};
      o_rom_req          <= 1'b0;
    end else begin
      o_timer_mod_load <= 1'b0;
      if (sys_wr) begin
        if (nw_addr[3:0] == `DMRA_SYS_AR3)
          sys[nw_addr[3:0]] <= nw_data & `DMRA_AR3_KEEP; // see RL10
        else
          sys[nw_addr[3:0]] <= nw_data;
      end
      if (dbf_wr)
        dbf[~nw_addr[1:0]] <= nw_data; // see RL5
      // unimplemented or read-only control nibbles keep their value
      if (ctrl_wr)
        ctrl[i_rf_addr[5:0]] <= sys[`DMRA_SYS_WR]; // see RL15 see RL17 see RL18
      // buffer transfers
      if (i_xfer_put) begin
        case (i_xfer_addr) // see RL21
          `DMRA_PA_CARRIER_LOW:
            o_carrier_low_mod <= dbf_word[7:0]; // see RL7
          `DMRA_PA_CARRIER_HIGH:
            o_carrier_high_mod <= dbf_word[7:0]; // see RL8
          `DMRA_PA_TIMER_MODULO: begin
            o_timer_mod      <= dbf_word[7:0]; // see RL6
            o_timer_mod_load <= 1'b1;
          end
          `DMRA_PA_ADDR_POINTER: begin
            sys[`DMRA_SYS_AR3] <= dbf[3] & `DMRA_AR3_KEEP; // see RL9
            sys[`DMRA_SYS_AR2] <= dbf[2];
            sys[`DMRA_SYS_AR1] <= dbf[1];
            sys[`DMRA_SYS_AR0] <= dbf[0];
          end
          default: begin
            // read-only count and unused addresses take nothing
          end
        endcase // see RL12
      end else if (i_xfer_get) begin
        case (i_xfer_addr) // see RL21
          `DMRA_PA_CARRIER_LOW: begin
            dbf[0] <= o_carrier_low_mod[3:0]; // see RL7
            dbf[1] <= o_carrier_low_mod[7:4];
          end
          `DMRA_PA_CARRIER_HIGH: begin
            dbf[0] <= o_carrier_high_mod[3:0]; // see RL8
            dbf[1] <= o_carrier_high_mod[7:4];
          end
          `DMRA_PA_TIMER_COUNT: begin
            dbf[0] <= i_timer_count[3:0]; // see RL6
            dbf[1] <= i_timer_count[7:4];
          end
          `DMRA_PA_ADDR_POINTER: begin
            dbf[3] <= sys[`DMRA_SYS_AR3] & `DMRA_AR3_KEEP; // see RL10
            dbf[2] <= sys[`DMRA_SYS_AR2];
            dbf[1] <= sys[`DMRA_SYS_AR1];
            dbf[0] <= sys[`DMRA_SYS_AR0];
          end
          default: begin
            // undefined value: the low buffer pair is returned as zero
            dbf[0] <= `DMRA_NIB_ZERO; // see RL12
            dbf[1] <= `DMRA_NIB_ZERO;
          end
        endcase
      end else if (o_rom_req && i_rom_valid) begin
        dbf[3] <= i_rom_data[15:12]; // see RL11
        dbf[2] <= i_rom_data[11:8];
        dbf[1] <= i_rom_data[7:4];
        dbf[0] <= i_rom_data[3:0];
      end
      // table read: pointer latched, request held until the word returns
      if (i_table_read && !o_rom_req) begin
        o_rom_req  <= 1'b1; // see RL11
        o_rom_addr <= ar_word[ROM_AW-1:0];
      end else if (o_rom_req && i_rom_valid) begin
        o_rom_req <= 1'b0;
      end
    end
  end

endmodule // dmra_access

// ### sim/dmra_chk.sv
// assertion checker of the memory access unit
`timescale 1ns/1ps
module dmra_chk #(parameter ROM_AW = 14) (
  input wire              i_clk,
  input wire              i_nrst,
  input wire              i_mem_re,
  input wire              i_xfer_put,
  input wire [7:0]        i_xfer_addr,
  input wire              i_table_read,
  input wire              i_rom_valid,
  input wire [3:0]        i_key_a,
  input wire              i_standby,
  input wire [3:0]        o_rdata,
  input wire              o_rvalid,
  input wire [7:0]        o_carrier_low_mod,
  input wire [7:0]        o_timer_mod,
  input wire              o_timer_mod_load,
  input wire [ROM_AW-1:0] o_rom_addr,
  input wire              o_rom_req,
  input wire              o_wake
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_put(a);
    i_xfer_put && i_xfer_addr == a;
  endsequence
  sequence s_wait_word;
    o_rom_req && !i_rom_valid;
  endsequence
  rd_answer_a: assert property (i_mem_re |=> o_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (!o_rvalid |-> $stable(o_rdata))
    else $error("read data moved");
  mod_load_a: assert property (s_put(8'h06) |=> o_timer_mod_load)
    else $error("no modulo load pulse");
  load_cause_a: assert property (o_timer_mod_load |-> $past(i_xfer_put && i_xfer_addr == 8'h06))
    else $error("stray modulo load");
  bad_put_a: assert property (i_xfer_put && !(i_xfer_addr inside {8'h03, 8'h04, 8'h06})
    |=> $stable(o_carrier_low_mod) && $stable(o_timer_mod))
    else $error("bad put changed a register");
  low_hold_a: assert property (!(i_xfer_put && i_xfer_addr == 8'h03)
    |=> $stable(o_carrier_low_mod))
    else $error("carrier low moved");
  rom_start_a: assert property (i_table_read && !o_rom_req |=> o_rom_req)
    else $error("table read not started");
  rom_wait_a: assert property (s_wait_word |=> o_rom_req && $stable(o_rom_addr))
    else $error("fetch dropped early");
  rom_done_a: assert property (o_rom_req && i_rom_valid |=> !o_rom_req)
    else $error("fetch not closed");
  key_idle_a: assert property ((i_key_a == 4'hF) [*8] |-> !o_wake)
    else $error("wake without key");
  wake_gate_a: assert property (!i_standby [*3] |-> !o_wake)
    else $error("wake outside standby");
endmodule // dmra_chk
bind dmra_access dmra_chk #(.ROM_AW(ROM_AW)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_mem_re(i_mem_re), .i_xfer_put(i_xfer_put),
  .i_xfer_addr(i_xfer_addr), .i_table_read(i_table_read), .i_rom_valid(i_rom_valid),
  .i_key_a(i_key_a), .i_standby(i_standby), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_carrier_low_mod(o_carrier_low_mod), .o_timer_mod(o_timer_mod),
  .o_timer_mod_load(o_timer_mod_load), .o_rom_addr(o_rom_addr), .o_rom_req(o_rom_req),
  .o_wake(o_wake)
);

// ### sim/dmra_periph.sv
// program memory and timer stand-in facing the access unit
`timescale 1ns/1ps
module dmra_periph #(parameter ROM_AW = 14) (
  input  wire              i_clk,
  input  wire              i_nrst,
  input  wire              i_req,
  input  wire [ROM_AW-1:0] i_addr,
  input  wire [3:0]        i_wait,
  input  wire [7:0]        i_count,
  output reg               o_valid,
  output reg  [15:0]       o_data,
  output reg  [7:0]        o_count
);
  reg [3:0] wait_cnt;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid  <= 1'b0;
      o_data   <= 16'h0000;
      o_count  <= 8'h00;
      wait_cnt <= 4'h0;
    end else begin
      o_count <= i_count;
      if (i_req && !o_valid && wait_cnt == i_wait) begin
        o_valid <= 1'b1;
        o_data  <= {i_addr[7:0], ~i_addr[7:0]};
      end else begin
        o_valid  <= 1'b0;
        o_data   <= ~o_data; // stale word must never pass for data
        wait_cnt <= (i_req && !o_valid) ? wait_cnt + 4'h1 : 4'h0;
      end
    end
  end
endmodule // dmra_periph

// ### sim/testbench.sv
// self-checking bench of the memory access unit
`timescale 1ns/1ps
module testbench;
  localparam [39:0]  pa = 40'h0304060510;
  localparam [39:0]  pd = 40'hA5C35E1122;
  localparam [119:0] pe = 120'hA50000_A5C300_A5C35E_A5C35E_A5C35E;
  localparam [47:0]  ga = 48'h030405060310;
  localparam [47:0]  ge = 48'hA5C37B00A500;
  reg         clk = 1'b0, nrst = 1'b0, we = 1'b0, re = 1'b0, opv = 1'b0, pk = 1'b0;
  reg         pw = 1'b0, peripheral_write_transfer = 1'b0, peripheral_read_transfer = 1'b0, trd = 1'b0, stby = 1'b0;
  reg  [1:0]  bank = 2'h0, opc = 2'h0;
  reg  [6:0]  ma = 7'h00, rfa = 7'h00;
  reg  [3:0]  wd = 4'h0, col = 4'h0, key = 4'hF, rwait = 4'h0;
  reg  [7:0]  xa = 8'h00, tcnt = 8'h7B;
  wire [3:0]  rdata;
  wire [7:0]  clo, chi, tmod, tc;
  wire [13:0] raddr;
  wire [15:0] rword;
  wire        rvalid, tload, rreq, rvld, wake;
  integer     fails = 0, samples_checked = 0, i;
  dmra_access dut (
    .i_clk(clk), .i_nrst(nrst), .i_mem_we(we), .i_mem_re(re), .i_mem_bank(bank),
    .i_mem_addr(ma), .i_mem_wdata(wd), .i_op_valid(opv), .i_op_code(opc), .i_op_col(col),
    .i_file_read_instruction(pk), .i_file_write_instruction(pw), .i_rf_addr(rfa), .i_xfer_put(peripheral_write_transfer), .i_xfer_get(peripheral_read_transfer),
    .i_xfer_addr(xa), .i_timer_count(tc), .i_table_read(trd), .i_rom_valid(rvld),
    .i_rom_data(rword), .i_key_a(key), .i_standby(stby), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_carrier_low_mod(clo), .o_carrier_high_mod(chi),
    .o_timer_mod(tmod), .o_timer_mod_load(tload), .o_rom_addr(raddr), .o_rom_req(rreq),
    .o_wake(wake)
  );
  dmra_periph far (
    .i_clk(clk), .i_nrst(nrst), .i_req(rreq), .i_addr(raddr), .i_wait(rwait),
    .i_count(tcnt), .o_valid(rvld), .o_data(rword), .o_count(tc)
  );
  initial begin
    forever #12.5 clk = ~clk;
  end
  task chk(input string n, input [23:0] s, input [23:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("[ERR] %s exp %h got %h", n, e, s);
      end
    end
  endtask
  task mw(input [1:0] b, input [6:0] a, input [3:0] d);
    begin
      @(negedge clk);
      {bank, ma, wd, we} = {b, a, d, 1'b1};
      @(negedge clk);
      we = 1'b0;
    end
  endtask
  task mr(input [1:0] b, input [6:0] a, input [3:0] e);
    begin
      @(negedge clk);
      {bank, ma, re} = {b, a, 1'b1};
      @(negedge clk);
      re = 1'b0;
      chk("rd", {rvalid, rdata}, {1'b1, e});
    end
  endtask
  task bufw(input [15:0] v);
    integer j;
    for (j = 0; j < 4; j = j + 1) mw(2'h0, 7'h0C + j[6:0], v[15-4*j-:4]);
  endtask
  task bufr(input [15:0] v);
    integer j;
    for (j = 0; j < 4; j = j + 1) mr(2'h0, 7'h0C + j[6:0], v[15-4*j-:4]);
  endtask
  // one strobe: 0 op, 1 file_read_instruction, 2 file_write_instruction, 3 put, 4 get, 5 table read
  task go(input [2:0] k, input [7:0] a, input [1:0] b, input [6:0] m);
    begin
      @(negedge clk);
      {xa, rfa, col, bank, ma} = {a, a[6:0], a[3:0], b, m};
      {opv, pk, pw, peripheral_write_transfer, peripheral_read_transfer, trd} = 6'h20 >> k;
      @(negedge clk);
      {opv, pk, pw, peripheral_write_transfer, peripheral_read_transfer, trd} = 6'h00;
      @(negedge clk);
    end
  endtask
  task final_report;
    begin
      if (fails == 0 && samples_checked > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  initial begin
    #(25 * 6000);
    fails = fails + 1;
    final_report;
  end
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    bufr(16'h0320);
    mw(2'h0, 7'h7E, 4'hB);
    mw(2'h0, 7'h7D, 4'h6);
    mw(2'h3, 7'h21, 4'h9);
    mw(2'h3, 7'h24, 4'hC);
    mw(2'h3, 7'h22, 4'h8);
    mw(2'h1, 7'h10, 4'h5);
    go(3'h0, 8'h03, 2'h3, 7'h21);
    mr(2'h2, 7'h53, 4'h9);
    opc = 2'h3;
    go(3'h0, 8'h03, 2'h3, 7'h24);
    mr(2'h2, 7'h53, 4'h8);
    opc = 2'h2;
    go(3'h0, 8'h03, 2'h3, 7'h22);
    mr(2'h2, 7'h53, 4'h0);
    opc = 2'h1;
    go(3'h0, 8'h03, 2'h1, 7'h10);
    mr(2'h1, 7'h10, 4'h0);
    for (i = 0; i < 5; i = i + 1) begin
      bufw({8'h00, pd[39-8*i-:8]});
      go(3'h3, pa[39-8*i-:8], 2'h0, 7'h00);
      chk("put", {clo, chi, tmod}, pe[119-24*i-:24]);
    end
    for (i = 0; i < 6; i = i + 1) begin
      go(3'h4, ga[47-8*i-:8], 2'h0, 7'h00);
      bufr({8'h00, ge[47-8*i-:8]});
    end
    bufw(16'hF123);
    go(3'h3, 8'h40, 2'h0, 7'h00);
    mr(2'h1, 7'h74, 4'h3);
    mr(2'h1, 7'h77, 4'h3);
    bufw(16'hFFFF);
    go(3'h4, 8'h40, 2'h0, 7'h00);
    bufr(16'h3123);
    for (i = 0; i < 2; i = i + 1) begin
      rwait = 4'h3 * i[3:0];
      bufw({8'h00, 8'h45 + i[7:0]});
      go(3'h3, 8'h40, 2'h0, 7'h00);
      go(3'h5, 8'h00, 2'h0, 7'h00);
      chk("raddr", raddr, 14'h0045 + i[13:0]);
      while (rreq !== 1'b0 && i < 40) @(negedge clk);
      bufr({8'h45 + i[7:0], ~(8'h45 + i[7:0])});
    end
    mw(2'h0, 7'h05, 4'h1);
    mw(2'h0, 7'h78, 4'h6);
    go(3'h2, 8'h05, 2'h0, 7'h00);
    mw(2'h0, 7'h78, 4'h0);
    go(3'h1, 8'h05, 2'h0, 7'h00);
    mr(2'h0, 7'h78, 4'h6);
    mr(2'h0, 7'h05, 4'h1);
    mw(2'h0, 7'h78, 4'h9);
    go(3'h2, 8'h08, 2'h0, 7'h00);
    go(3'h1, 8'h08, 2'h0, 7'h00);
    mr(2'h0, 7'h78, 4'h0);
    mw(2'h2, 7'h45, 4'hA);
    go(3'h1, 8'h45, 2'h2, 7'h00);
    mr(2'h1, 7'h78, 4'hA);
    go(3'h2, 8'h46, 2'h1, 7'h00);
    mr(2'h1, 7'h46, 4'hA);
    key = 4'hA;
    repeat (8) @(negedge clk);
    mw(2'h0, 7'h70, 4'h5);
    mr(2'h0, 7'h70, 4'hA);
    key = 4'hF;
    stby = 1'b1;
    repeat (10) @(negedge clk);
    chk("wake", wake, 1'b0);
    key = 4'hE;
    repeat (8) @(negedge clk);
    chk("wake", wake, 1'b1);
    final_report;
  end
endmodule // testbench
